// File: src/cis_irq_status.sv
// Behaviour
// - Writing one to enable-set port sets the mask bit for bits 0-7 and 16-28; zero leaves it.
// - Writing one to enable-clear port clears the mask bit; zero leaves it.
// - Mask register reads one for each enabled source, status bit positions.
// - Mailboxes bits 0-7, state/power/timer bits 16-23, faults bits 24-28.
// - Mailbox event bit is one while that mailbox is ready or aborted.
// - Error-active flag sets when neither passive nor bus-off.
// - Warning flag sets when either error count is 96 or more.
// - Passive flag sets when either error count is 128 or more.
// - Bus-off flag sets when transmit error count is 256 or more.
// - State, timer, capture and fault flags are sticky, cleared by status read.
// - Low-power bit reads one while in low-power mode.
// - Awake bit reads one while not in low-power mode.
// - Timer-wrap flag sets when timer rolls from all ones to zero.
// - Capture flag sets on frame start, or frame end when selected.
// - CRC fault flag sets on a reception CRC mismatch.
// - Stuff fault flag sets on more than five equal bits.
// - Ack fault flag sets when no dominant ack slot seen.
// - Form fault flag sets on fixed-form field violations.
// - Bit fault flag sets when monitored level differs from driven.
// - Receiver-busy bit follows the receiver acquiring any frame.
// - Transmitter-busy bit follows the transmitter sending a frame.
// - Overload-busy bit follows overload frame transmission.
// - Interrupt asserted while any status bit and its mask bit are set.
`include "cis_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cis_irq_status
	import cis_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire cis_core_type core_i,
	output logic low_power_req_o,
	output logic stamp_at_end_o,
	output logic irq_o
);

////////////////////////////////////////////////////////////////////////////////

	function automatic cis_sticky_type sticky_next(input cis_sticky_type old_v,
		input cis_sticky_type set_v, input logic clr);
		// A set in the clearing cycle wins, so no event is lost to a read.
		sticky_next = clr ? set_v : (old_v | set_v);
	endfunction

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a == off);
	endfunction

////////////////////////////////////////////////////////////////////////////////

	logic setup;
	logic access;
	logic mapped;
	logic wr_en_set;
	logic wr_en_clr;
	logic wr_config;
	logic rd_flags;
	logic [31:0] mask;
	logic [31:0] next_mask;
	logic [31:0] config_reg;
	logic [31:0] next_config_reg;
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic pslverr;
	logic next_pslverr;
	cis_sticky_type sticky;
	cis_sticky_type next_sticky;
	cis_sticky_type sticky_set;
	logic [15:0] timer_prev;
	logic [15:0] next_timer_prev;
	logic [31:0] status;
	logic passive;
	logic bus_off;

	assign setup = psel_i && !penable_i;
	assign access = psel_i && penable_i;
	assign mapped = addr_is(paddr_i, `CIS_OFF_CONFIG) || addr_is(paddr_i, `CIS_OFF_EN_SET)
		|| addr_is(paddr_i, `CIS_OFF_EN_CLR) || addr_is(paddr_i, `CIS_OFF_EN_STATE)
		|| addr_is(paddr_i, `CIS_OFF_FLAGS);
	assign wr_en_set = access && pwrite_i && addr_is(paddr_i, `CIS_OFF_EN_SET);
	assign wr_en_clr = access && pwrite_i && addr_is(paddr_i, `CIS_OFF_EN_CLR);
	assign wr_config = access && pwrite_i && addr_is(paddr_i, `CIS_OFF_CONFIG);
	// The snapshot and the clear share one edge, so nothing set between them is lost.
	assign rd_flags = setup && !pwrite_i && addr_is(paddr_i, `CIS_OFF_FLAGS);

////////////////////////////////////////////////////////////////////////////////

	assign bus_off = core_i.tx_count >= `CIS_BUS_OFF_LIMIT;
	assign passive = (core_i.tx_count >= `CIS_PASSIVE_LIMIT)
		|| ({1'b0, core_i.rx_count} >= `CIS_PASSIVE_LIMIT);

	always_comb begin
		sticky_set = '0;
		sticky_set.error_active_flag = !passive && !bus_off;
		sticky_set.warn = (core_i.tx_count >= `CIS_WARN_LIMIT)
			|| ({1'b0, core_i.rx_count} >= `CIS_WARN_LIMIT);
		sticky_set.passive_state_flag = passive;
		sticky_set.bus_off_flag = bus_off;
		sticky_set.timer_wrap_flag = (timer_prev == `CIS_TIMER_MAX) && (core_i.timer == `CIS_TIMER_ZERO);
		sticky_set.frame_time_capture_flag = config_reg[`CIS_CFG_STAMP_AT_FRAME_END] ? core_i.eof : core_i.sof;
		sticky_set.fault = core_i.fault;
		next_sticky = sticky_next(sticky, sticky_set, rd_flags);
		next_timer_prev = core_i.timer;
	end

	always_comb begin
		status = `CIS_RESET_WORD;
		status[`CIS_MB_LSB +: 8] = core_i.mb_ready | core_i.mb_abort;
		status[`CIS_EVT_LSB +: 4] = {sticky.bus_off_flag, sticky.passive_state_flag, sticky.warn, sticky.error_active_flag};
		status[`CIS_EVT_LSB + 4] = core_i.lp_active;
		status[`CIS_EVT_LSB + 5] = !core_i.lp_active;
		status[`CIS_EVT_LSB + 6] = sticky.timer_wrap_flag;
		status[`CIS_EVT_LSB + 7] = sticky.frame_time_capture_flag;
		status[`CIS_FAULT_LSB +: 5] = sticky.fault;
		status[`CIS_RX_BUSY] = core_i.rx_busy;
		status[`CIS_TX_BUSY] = core_i.tx_busy;
		status[`CIS_OVL_BUSY] = core_i.ovl_busy;
	end

////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_mask = mask;
		if (wr_en_set) begin
			next_mask = next_mask | (pwdata_i & `CIS_SRC_MASK);
		end
		if (wr_en_clr) begin
			next_mask = next_mask & ~pwdata_i;
		end
		next_config_reg = config_reg;
		if (wr_config) begin
			next_config_reg = pwdata_i & `CIS_CFG_MASK;
		end
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup) begin
			next_pslverr = !mapped;
			next_prdata = `CIS_RESET_WORD;
			if (!pwrite_i) begin
				case (paddr_i)
					`CIS_OFF_CONFIG: begin
						next_prdata = config_reg;
					end
					`CIS_OFF_EN_STATE: begin
						next_prdata = mask;
					end
					`CIS_OFF_FLAGS: begin
						next_prdata = status;
					end
					default: begin
						next_prdata = `CIS_RESET_WORD;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask <= `CIS_RESET_WORD;
			config_reg <= `CIS_RESET_WORD;
			prdata <= `CIS_RESET_WORD;
			pslverr <= 1'b0;
			sticky <= '0;
			timer_prev <= `CIS_TIMER_ZERO;
		end else begin
			mask <= next_mask;
			config_reg <= next_config_reg;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			sticky <= next_sticky;
			timer_prev <= next_timer_prev;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// One wait-free access cycle: data is staged on the setup edge.
	assign pready_o = 1'b1;
	assign prdata_o = prdata;
	assign pslverr_o = pslverr && access;
	assign low_power_req_o = config_reg[`CIS_CFG_LPM];
	assign stamp_at_end_o = config_reg[`CIS_CFG_STAMP_AT_FRAME_END];
	assign irq_o = |(status & mask);

////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_set_port_sets: assert property (
		wr_en_set |=> ((mask & $past(pwdata_i) & `CIS_SRC_MASK) == ($past(pwdata_i) & `CIS_SRC_MASK)))
		else $error("enable-set write did not set mask bits");

	a_set_zero_keeps: assert property (
		(wr_en_set && !wr_en_clr) |=> ((mask & ~$past(pwdata_i)) == ($past(mask) & ~$past(pwdata_i))))
		else $error("enable-set write changed a bit written as zero");

	a_clr_port_clears: assert property (
		wr_en_clr |=> ((mask & $past(pwdata_i)) == 32'h0000_0000))
		else $error("enable-clear write left a mask bit set");

	a_mask_read_back: assert property (
		(setup && !pwrite_i && paddr_i == `CIS_OFF_EN_STATE) |=> (prdata_o == $past(mask)))
		else $error("mask readback mismatch");

	a_mailbox_event: assert property (
		status[7:0] == (core_i.mb_ready | core_i.mb_abort))
		else $error("mailbox event bits wrong");

	a_bus_off_sticky: assert property (
		(core_i.tx_count >= `CIS_BUS_OFF_LIMIT) |=> sticky.bus_off_flag)
		else $error("bus-off flag not set");

	a_warn_sets: assert property (
		(core_i.rx_count >= 8'h60) |=> sticky.warn)
		else $error("warning flag not set");

	a_read_clears: assert property (
		(rd_flags && !sticky_set.timer_wrap_flag) |=> !sticky.timer_wrap_flag)
		else $error("timer-wrap flag survived a status read");

	a_wrap_sets: assert property (
		($past(core_i.timer) == `CIS_TIMER_MAX && core_i.timer == `CIS_TIMER_ZERO) |=> sticky.timer_wrap_flag [*1])
		else $error("timer-wrap flag not set on roll-over");

	a_flag_holds: assert property (
		(sticky.fault[0] && !rd_flags) |=> sticky.fault[0])
		else $error("crc fault flag dropped without a read");

	a_power_pair: assert property (
		status[`CIS_EVT_LSB + 4] != status[`CIS_EVT_LSB + 5])
		else $error("low-power and awake bits agree");

	a_stamp_irq: assert property (
		(sticky.frame_time_capture_flag && mask[`CIS_EVT_LSB + 7]) |-> irq_o)
		else $error("capture interrupt missing");

	a_irq_level: assert property (
		irq_o == ((status & mask) != 32'h0000_0000))
		else $error("interrupt level wrong");

	c_status_read: cover property (rd_flags ##1 access ##1 sticky == '0);
	c_mask_then_irq: cover property (wr_en_set ##[1:20] irq_o);
	c_bus_off: cover property (sticky.bus_off_flag && irq_o);
	c_wrap: cover property (sticky_set.timer_wrap_flag);

endmodule
`default_nettype wire

// File: src/cis_map.svh
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH
`define CIS_OFF_CONFIG 12'h000
`define CIS_OFF_EN_SET 12'h004
`define CIS_OFF_EN_CLR 12'h008
`define CIS_OFF_EN_STATE 12'h00C
`define CIS_OFF_FLAGS 12'h010
`define CIS_CFG_LPM 1
`define CIS_CFG_STAMP_AT_FRAME_END 4
`define CIS_CFG_MASK 32'h0000_0012
`define CIS_MB_LSB 0
`define CIS_EVT_LSB 16
`define CIS_FAULT_LSB 24
`define CIS_RX_BUSY 29
`define CIS_TX_BUSY 30
`define CIS_OVL_BUSY 31
`define CIS_SRC_MASK 32'h1FFF_00FF
`define CIS_WARN_LIMIT 9'h060
`define CIS_PASSIVE_LIMIT 9'h080
`define CIS_BUS_OFF_LIMIT 9'h100
`define CIS_TIMER_MAX 16'hFFFF
`define CIS_TIMER_ZERO 16'h0000
`define CIS_RESET_WORD 32'h0000_0000
`endif

// File: src/cis_pkg.sv
package cis_pkg;
	typedef struct packed {
		logic [8:0] tx_count;
		logic [7:0] rx_count;
		logic [7:0] mb_ready;
		logic [7:0] mb_abort;
		logic lp_active;
		logic rx_busy;
		logic tx_busy;
		logic ovl_busy;
		logic sof;
		logic eof;
		logic [4:0] fault;
		logic [15:0] timer;
	} cis_core_type;
	typedef struct packed {
		logic [4:0] fault;
		logic frame_time_capture_flag;
		logic timer_wrap_flag;
		logic bus_off_flag;
		logic passive_state_flag;
		logic warn;
		logic error_active_flag;
	} cis_sticky_type;
endpackage

// File: tb/cis_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cis_core_model
	import cis_pkg::*;
(
	input wire logic clk_i,
	output var cis_core_type core_o
);
	initial core_o = '0;
	////////////////////////////////////////////////////////////////
	// Levels change one edge in, then hold for a full cycle.
	task automatic set_lv(input logic [8:0] tx, input logic [7:0] rx, input logic [7:0] rdy,
		input logic [7:0] abt, input logic [3:0] bz);
		@(posedge clk_i);
		core_o.tx_count <= tx;
		core_o.rx_count <= rx;
		core_o.mb_ready <= rdy;
		core_o.mb_abort <= abt;
		{core_o.lp_active, core_o.rx_busy, core_o.tx_busy, core_o.ovl_busy} <= bz;
		@(posedge clk_i);
	endtask
	// Events last one cycle, as the engine strobes them.
	task automatic pulse(input logic s, input logic e, input logic [4:0] f);
		@(posedge clk_i);
		core_o.sof <= s;
		core_o.eof <= e;
		core_o.fault <= f;
		@(posedge clk_i);
		core_o.sof <= 1'b0;
		core_o.eof <= 1'b0;
		core_o.fault <= 5'h00;
	endtask
	task automatic wrap();
		@(posedge clk_i);
		core_o.timer <= 16'hFFFF;
		@(posedge clk_i);
		core_o.timer <= 16'h0000;
	endtask
endmodule
`default_nettype wire

// File: tb/cis_irq_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module cis_irq_status_tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sae;
	logic lpr;
	logic irq;
	cis_pkg::cis_core_type core;
	int err_total = 0;
	int n_tests = 0;
	int i;
	logic [31:0] rd;
	logic er;
	logic [8:0] tx_t [4] = '{9'h060, 9'h000, 9'h07F, 9'h100};
	logic [7:0] rx_t [4] = '{8'h00, 8'h80, 8'h60, 8'h00};
	logic [3:0] st_t [4] = '{4'h3, 4'h6, 4'h3, 4'hE};
	cis_irq_status DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .core_i(core), .low_power_req_o(lpr), .stamp_at_end_o(sae), .irq_o(irq));
	cis_core_model CORE (.clk_i(clk_i), .core_o(core));
	initial forever #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// About 170 cycles of work; the limit of 10,000 cycles leaves wide margin.
	initial begin
		#100us;
		err_total++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		xfer(0, 12'h00C, 0); `CHK("mask_rst", 32'h0000_0000, rd)
		xfer(0, 12'h010, 0); `CHK("flags_rst", 32'h0021_0000, rd)
		xfer(1, 12'h004, 32'hFFFF_FFFF); xfer(0, 12'h00C, 0); `CHK("mask_set", 32'h1FFF_00FF, rd)
		xfer(1, 12'h008, 32'h0F00_00F0); xfer(1, 12'h004, 0); xfer(0, 12'h00C, 0);
		`CHK("mask_clr", 32'h10FF_000F, rd)
		xfer(1, 12'h008, 32'hFFFF_FFFF);
		xfer(0, 12'h100, 0); `CHK("unmapped", 1'b1, er)
		// Two reads: the first drops flags that the previous levels left behind.
		for (i = 0; i < 4; i++) begin
			CORE.set_lv(tx_t[i], rx_t[i], 8'h00, 8'h00, 4'h0);
			xfer(0, 12'h010, 0); xfer(0, 12'h010, 0);
			`CHK("err_state", st_t[i], rd[19:16])
		end
		CORE.set_lv(9'h000, 8'h00, 8'h05, 8'h80, 4'hF); xfer(0, 12'h010, 0);
		`CHK("live_on", {3'h7, 2'b01, 8'h85}, {rd[31:29], rd[21:20], rd[7:0]})
		CORE.set_lv(9'h000, 8'h00, 8'h00, 8'h00, 4'h0); xfer(0, 12'h010, 0);
		`CHK("live_off", {3'h0, 2'b10, 8'h00}, {rd[31:29], rd[21:20], rd[7:0]})
		for (i = 0; i < 5; i++) begin
			CORE.pulse(0, 0, 5'h01 << i); xfer(0, 12'h010, 0);
			`CHK("fault", 5'h01 << i, rd[28:24])
			xfer(0, 12'h010, 0); `CHK("fault_clr", 5'h00, rd[28:24])
		end
		CORE.pulse(0, 1, 0); xfer(0, 12'h010, 0); `CHK("eof_ignored", 1'b0, rd[23])
		xfer(1, 12'h000, 32'h0000_0010); `CHK("stamp_at_frame_end_out", 1'b1, sae)
		CORE.pulse(0, 1, 0); xfer(0, 12'h010, 0); `CHK("eof_capture", 1'b1, rd[23])
		xfer(1, 12'h000, 0);
		CORE.wrap(); @(posedge clk_i); xfer(0, 12'h010, 0); `CHK("timer_wrap", 1'b1, rd[22])
		xfer(1, 12'h000, 32'h0000_0002); `CHK("lp_req_out", 1'b1, lpr)
		xfer(1, 12'h000, 0); `CHK("lp_req_off", 1'b0, lpr)
		xfer(1, 12'h004, 32'h0080_0000); `CHK("irq_idle", 1'b0, irq)
		CORE.pulse(1, 0, 0); @(posedge clk_i); `CHK("irq_capture", 1'b1, irq)
		xfer(0, 12'h010, 0); `CHK("irq_cleared", 1'b0, irq)
		xfer(1, 12'h004, 32'h0000_0001); CORE.set_lv(9'h000, 8'h00, 8'h01, 8'h00, 4'h0);
		`CHK("irq_mb", 1'b1, irq)
		xfer(1, 12'h008, 32'h0000_0001); `CHK("irq_masked", 1'b0, irq)
		wrap_up();
	end
endmodule
`default_nettype wire
